// ==== occp_consts.vh ====
// constants for the operator console panel control block
// assumes inclusion by occp_top.v and by the testbench
`ifndef OCCP_CONSTS_VH
`define OCCP_CONSTS_VH

// register byte offsets
`define OCCP_ADDR_STATUS 8'h00
`define OCCP_ADDR_MASK 8'h04
`define OCCP_ADDR_CTRL 8'h08
`define OCCP_ADDR_LAMPS 8'h0C
`define OCCP_ADDR_ALARM_DUR 8'h10
`define OCCP_ADDR_CURSOR 8'h14

// interrupt status bit positions
`define OCCP_EV_SYS_CLEAR 0
`define OCCP_EV_BOOT 1
`define OCCP_EV_RUN 2
`define OCCP_EV_EXT_IRQ 3
`define OCCP_EV_PWR_UP 4
`define OCCP_EV_PWR_DOWN 5
`define OCCP_EV_CONS_CLEAR 6
`define OCCP_EV_ALARM_CLEAR 7
`define OCCP_EV_W 8

// ctrl bits
`define OCCP_CTRL_SILENCE 0
`define OCCP_CTRL_MSG_SET 1

// timing
`define OCCP_CLK_HZ 40000000
`define OCCP_LAMP_TEST_MS 2000
`define OCCP_LAMP_TEST_CYC (`OCCP_CLK_HZ / 1000 * `OCCP_LAMP_TEST_MS)
`define OCCP_DEBOUNCE_US 5000
`define OCCP_DEBOUNCE_CYC (`OCCP_CLK_HZ / 1000000 * `OCCP_DEBOUNCE_US)
`define OCCP_ALARM_DUR_RST 32'h003D0900

// display geometry
`define OCCP_LINE_LEN 80
`define OCCP_LINES 24
`define OCCP_TAIL_LEN 8

`endif

// ==== occp_proc_model.sv ====
// stand-in for processor, channels and console power control
// assumes requests are one-cycle pulses on the same clock
`timescale 1ns/1ps
module occp_proc_model (
    input wire clk_i,
    input wire rst_i,
    input wire [2:0] fault_i,
    input wire system_clear_i,
    input wire boot_load_i,
    input wire run_req_i,
    output reg proc_run_o,
    output reg load_done_o,
    output wire power_fault_o,
    output wire proc_error_o,
    output wire proc_halt_point_o
);
    reg [3:0] load_cnt_reg;
    assign {proc_halt_point_o, proc_error_o, power_fault_o} = fault_i;
    always @(posedge clk_i)
    begin
        load_done_o <= (load_cnt_reg == 4'h1);
        if (rst_i || system_clear_i)
        begin
            proc_run_o <= 1'b0;
            load_cnt_reg <= 4'h0;
        end
        else
        begin
            if (run_req_i)
                proc_run_o <= 1'b1;
            if (boot_load_i)
                load_cnt_reg <= 4'h6;
            else if (load_cnt_reg != 4'h0)
                load_cnt_reg <= load_cnt_reg - 4'h1;
        end
    end
endmodule // occp_proc_model

// ==== occp_properties.sv ====
// assertions on the ports of occp_top
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module occp_props #(
    parameter LAMP_TEST_CYC = 50,
    parameter DEBOUNCE_CYC = 4
)(
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire proc_run_i,
    input wire power_fault_i,
    input wire proc_error_i,
    input wire proc_halt_point_i,
    input wire run_lamp_o,
    input wire console_power_fault_lamp_o,
    input wire processor_fault_lamp_o,
    input wire halt_point_lamp_o,
    input wire message_lamp_o,
    input wire alarm_o,
    input wire run_req_o,
    input wire external_irq_o,
    input wire power_up_o,
    input wire console_clear_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire all_lamps = run_lamp_o && console_power_fault_lamp_o && processor_fault_lamp_o
        && halt_point_lamp_o && message_lamp_o;
    ////////////////////////////////////////////////////////////
    a_run_lamp_on: assert property (proc_run_i |=> run_lamp_o)
        else $error("run lamp dark");
    a_pwr_fault_lamp: assert property
        (power_fault_i |=> console_power_fault_lamp_o)
        else $error("power fault lamp dark");
    a_proc_fault_lamp: assert property (proc_error_i |=> processor_fault_lamp_o)
        else $error("processor fault lamp dark");
    a_halt_lamp_on: assert property (proc_halt_point_i |=> halt_point_lamp_o)
        else $error("halt point lamp dark");
    a_lamp_test_on: assert property (console_clear_o |-> ##[0:3] all_lamps [*8])
        else $error("lamp test short");
    a_run_req_pulse: assert property (run_req_o |=> !run_req_o)
        else $error("run request too long");
    a_ext_irq_pulse: assert property (external_irq_o |=> !external_irq_o)
        else $error("interrupt request too long");
    a_pwr_up_pulse: assert property (power_up_o |=> !power_up_o)
        else $error("power up request too long");
    a_clear_pulse: assert property (console_clear_o |=> !console_clear_o)
        else $error("console clear too long");
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus not acked");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    c_lamp_test: cover property (console_clear_o);
    c_run_req: cover property (run_req_o);
    c_msg_alarm: cover property (alarm_o && message_lamp_o);
endmodule // occp_props
bind occp_top occp_props #(.LAMP_TEST_CYC(LAMP_TEST_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .proc_run_i(proc_run_i), .power_fault_i(power_fault_i),
    .proc_error_i(proc_error_i), .proc_halt_point_i(proc_halt_point_i),
    .run_lamp_o(run_lamp_o), .console_power_fault_lamp_o(console_power_fault_lamp_o),
    .processor_fault_lamp_o(processor_fault_lamp_o), .halt_point_lamp_o(halt_point_lamp_o),
    .message_lamp_o(message_lamp_o), .alarm_o(alarm_o), .run_req_o(run_req_o),
    .external_irq_o(external_irq_o), .power_up_o(power_up_o),
    .console_clear_o(console_clear_o));

// ==== occp_top.v ====
// operator console panel control: lamps, switch requests, lamp test, alarm
// assumes switches are raw pins, processor status from the same clock domain
//
// Behaviour
// - run lamp follows processor run mode
// - console power fault lamp follows fault
// - processor fault lamp on nonrecoverable error
// - halt point lamp while halted at display
// - system clear pulses processor, channels, units
// - bootstrap load starts with panel selections
// - load completion lights run lamp
// - run switch requests processor start
// - interrupt switch raises external interrupt
// - power switch edges start up/down sequences
// - console clear clears, lamps on two seconds
// - alarm clear silences alarm, message lamp off
// - alarm once entering last 8 positions
// - alarm once at bottom line start
// - alarm continuous while message lamp, silenceable
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "occp_consts.vh"

module occp_top #(
    parameter LAMP_TEST_CYC = `OCCP_LAMP_TEST_CYC,
    parameter DEBOUNCE_CYC = `OCCP_DEBOUNCE_CYC,
    parameter CHAN_W = 4,
    parameter DEV_W = 8
)(
    input wire clk_i,
    input wire rst_i,
    // wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg irq_o,
    // processor and power status, same clock domain
    input wire proc_run_i,
    input wire power_fault_i,
    input wire proc_error_i,
    input wire proc_halt_point_i,
    input wire load_done_i,
    input wire [6:0] cursor_col_i,
    input wire [4:0] cursor_row_i,
    // raw switch pins
    input wire sys_clear_switch_i,
    input wire boot_load_switch_i,
    input wire run_switch_i,
    input wire external_irq_switch_i,
    input wire power_switch_i,
    input wire console_clear_switch_i,
    input wire alarm_clear_switch_i,
    input wire [CHAN_W-1:0] chan_sel_i,
    input wire [DEV_W-1:0] dev_sel_i,
    // lamps and alarm
    output reg run_lamp_o,
    output reg console_power_fault_lamp_o,
    output reg processor_fault_lamp_o,
    output reg halt_point_lamp_o,
    output reg message_lamp_o,
    output reg alarm_o,
    // requests
    output reg system_clear_o,
    output reg boot_load_o,
    output reg [CHAN_W-1:0] boot_chan_o,
    output reg [DEV_W-1:0] boot_dev_o,
    output reg run_req_o,
    output reg external_irq_o,
    output reg power_up_o,
    output reg power_down_o,
    output reg console_clear_o
);

    ////////////////////////////////////////////////////////////////////////
    // switch synchronise and debounce
    localparam NSW = 7;
    wire [NSW-1:0] sw_raw = {alarm_clear_switch_i, console_clear_switch_i, power_switch_i,
        external_irq_switch_i, run_switch_i, boot_load_switch_i, sys_clear_switch_i};
    reg [NSW-1:0] sw_meta_reg;
    reg [NSW-1:0] sw_sync_reg;
    reg [NSW-1:0] sw_stable_reg;
    reg [NSW-1:0] sw_rise_reg;
    reg [NSW-1:0] sw_fall_reg;
    reg [31:0] db_cnt_reg [0:NSW-1];
    integer k;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sw_meta_reg <= 7'h00;
            sw_sync_reg <= 7'h00;
            sw_stable_reg <= 7'h00;
            sw_rise_reg <= 7'h00;
            sw_fall_reg <= 7'h00;
            for (k = 0; k < NSW; k = k + 1)
                db_cnt_reg[k] <= 32'h00000000;
        end
        else
        begin
            sw_meta_reg <= sw_raw;
            sw_sync_reg <= sw_meta_reg;
            for (k = 0; k < NSW; k = k + 1)
            begin
                sw_rise_reg[k] <= 1'b0;
                sw_fall_reg[k] <= 1'b0;
                if (sw_sync_reg[k] == sw_stable_reg[k])
                    db_cnt_reg[k] <= 32'h00000000;
                else if (db_cnt_reg[k] >= DEBOUNCE_CYC - 1)
                begin
                    db_cnt_reg[k] <= 32'h00000000;
                    sw_stable_reg[k] <= sw_sync_reg[k];
                    sw_rise_reg[k] <= sw_sync_reg[k];
                    sw_fall_reg[k] <= ~sw_sync_reg[k];
                end
                else
                    db_cnt_reg[k] <= db_cnt_reg[k] + 32'h00000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file
    reg [`OCCP_EV_W-1:0] status_reg;
    reg [`OCCP_EV_W-1:0] mask_reg;
    reg silence_reg;
    reg [31:0] alarm_dur_reg;
    reg msg_set_pulse_reg;
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i;
    // status order: sys clear, boot, run, irq, up, down, console, alarm
    wire [`OCCP_EV_W-1:0] ev_vec = {
        sw_rise_reg[6],
        sw_rise_reg[5],
        sw_fall_reg[4],
        sw_rise_reg[4],
        sw_rise_reg[3],
        sw_rise_reg[2],
        sw_rise_reg[1],
        sw_rise_reg[0]};
    wire [`OCCP_EV_W-1:0] events = {ev_vec[7:1], ev_vec[0]};
    reg lamp_test_reg;
    reg alarm_reg;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            status_reg <= 8'h00;
            mask_reg <= 8'h00;
            silence_reg <= 1'b0;
            alarm_dur_reg <= `OCCP_ALARM_DUR_RST;
            msg_set_pulse_reg <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            irq_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            msg_set_pulse_reg <= 1'b0;
            if (wb_wr && wb_sel_i[0] && wb_adr_i == `OCCP_ADDR_STATUS)
                status_reg <= (status_reg & ~wb_dat_i[7:0]) | events;
            else
                status_reg <= status_reg | events;
            if (wb_wr && wb_sel_i[0])
            begin
                if (wb_adr_i == `OCCP_ADDR_MASK)
                    mask_reg <= wb_dat_i[7:0];
                else if (wb_adr_i == `OCCP_ADDR_CTRL)
                begin
                    silence_reg <= wb_dat_i[`OCCP_CTRL_SILENCE];
                    msg_set_pulse_reg <= wb_dat_i[`OCCP_CTRL_MSG_SET];
                end
            end
            if (wb_wr && wb_adr_i == `OCCP_ADDR_ALARM_DUR)
            begin
                if (wb_sel_i[0]) alarm_dur_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) alarm_dur_reg[15:8] <= wb_dat_i[15:8];
                if (wb_sel_i[2]) alarm_dur_reg[23:16] <= wb_dat_i[23:16];
                if (wb_sel_i[3]) alarm_dur_reg[31:24] <= wb_dat_i[31:24];
            end
            if (wb_req && !wb_we_i)
            begin
                if (wb_adr_i == `OCCP_ADDR_STATUS)
                    wb_dat_o <= {24'h000000, status_reg};
                else if (wb_adr_i == `OCCP_ADDR_MASK)
                    wb_dat_o <= {24'h000000, mask_reg};
                else if (wb_adr_i == `OCCP_ADDR_CTRL)
                    wb_dat_o <= {30'h0000000, message_lamp_o, silence_reg};
                else if (wb_adr_i == `OCCP_ADDR_LAMPS)
                    wb_dat_o <= {25'h0000000, alarm_reg, lamp_test_reg, message_lamp_o,
                        halt_point_lamp_o, processor_fault_lamp_o,
                        console_power_fault_lamp_o, run_lamp_o};
                else if (wb_adr_i == `OCCP_ADDR_ALARM_DUR)
                    wb_dat_o <= alarm_dur_reg;
                else if (wb_adr_i == `OCCP_ADDR_CURSOR)
                    wb_dat_o <= {19'h00000, cursor_row_i, 1'b0, cursor_col_i};
                else
                    wb_dat_o <= 32'h00000000;
            end
            irq_o <= |(status_reg & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request pulses
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            system_clear_o <= 1'b0;
            boot_load_o <= 1'b0;
            boot_chan_o <= {CHAN_W{1'b0}};
            boot_dev_o <= {DEV_W{1'b0}};
            run_req_o <= 1'b0;
            external_irq_o <= 1'b0;
            power_up_o <= 1'b0;
            power_down_o <= 1'b0;
            console_clear_o <= 1'b0;
        end
        else
        begin
            system_clear_o <= sw_rise_reg[0];
            boot_load_o <= sw_rise_reg[1];
            if (sw_rise_reg[1])
            begin
                boot_chan_o <= chan_sel_i;
                boot_dev_o <= dev_sel_i;
            end
            run_req_o <= sw_rise_reg[2];
            external_irq_o <= sw_rise_reg[3];
            power_up_o <= sw_rise_reg[4];
            power_down_o <= sw_fall_reg[4];
            console_clear_o <= sw_rise_reg[5];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter helper
    function is_live;
        input [31:0] cnt;
        begin
            is_live = (cnt != 32'h00000000);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // lamp test and lamps
    reg [31:0] lamp_cnt_reg;
    reg msg_reg;
    reg load_run_reg;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lamp_test_reg <= 1'b0;
            lamp_cnt_reg <= 32'h00000000;
            msg_reg <= 1'b0;
            load_run_reg <= 1'b0;
            run_lamp_o <= 1'b0;
            console_power_fault_lamp_o <= 1'b0;
            processor_fault_lamp_o <= 1'b0;
            halt_point_lamp_o <= 1'b0;
            message_lamp_o <= 1'b0;
        end
        else
        begin
            if (sw_rise_reg[5])
            begin
                lamp_test_reg <= 1'b1;
                lamp_cnt_reg <= LAMP_TEST_CYC - 1;
            end
            else if (is_live(lamp_cnt_reg))
                lamp_cnt_reg <= lamp_cnt_reg - 32'h00000001;
            else
                lamp_test_reg <= 1'b0;
            if (msg_set_pulse_reg)
                msg_reg <= 1'b1;
            else if (sw_rise_reg[6])
                msg_reg <= 1'b0;
            // load completion lights run until processor reports mode itself
            if (load_done_i)
                load_run_reg <= 1'b1;
            else if (sw_rise_reg[0] || sw_rise_reg[1] || proc_run_i)
                load_run_reg <= 1'b0;
            run_lamp_o <= lamp_test_reg | proc_run_i | load_run_reg;
            console_power_fault_lamp_o <= lamp_test_reg | power_fault_i;
            processor_fault_lamp_o <= lamp_test_reg | proc_error_i;
            halt_point_lamp_o <= lamp_test_reg | proc_halt_point_i;
            message_lamp_o <= lamp_test_reg | msg_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm
    function in_tail;
        input [6:0] col;
        begin
            in_tail = (col >= `OCCP_LINE_LEN - `OCCP_TAIL_LEN) && (col < `OCCP_LINE_LEN);
        end
    endfunction

    reg [6:0] col_prev_reg;
    reg [4:0] row_prev_reg;
    reg [31:0] alarm_cnt_reg;
    wire tail_enter = in_tail(cursor_col_i) &&
        (!in_tail(col_prev_reg) || cursor_row_i != row_prev_reg);
    wire bottom_enter = (cursor_row_i == `OCCP_LINES - 1) && (cursor_col_i == 7'h00) &&
        !(row_prev_reg == `OCCP_LINES - 1 && col_prev_reg == 7'h00);
    wire alarm_trig = tail_enter | bottom_enter;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            col_prev_reg <= 7'h00;
            row_prev_reg <= 5'h00;
            alarm_cnt_reg <= 32'h00000000;
            alarm_reg <= 1'b0;
            alarm_o <= 1'b0;
        end
        else
        begin
            col_prev_reg <= cursor_col_i;
            row_prev_reg <= cursor_row_i;
            if (sw_rise_reg[6])
                alarm_cnt_reg <= 32'h00000000;
            else if (alarm_trig)
                alarm_cnt_reg <= alarm_dur_reg;
            else if (is_live(alarm_cnt_reg))
                alarm_cnt_reg <= alarm_cnt_reg - 32'h00000001;
            alarm_reg <= is_live(alarm_cnt_reg) |
                (msg_reg & ~silence_reg);
            alarm_o <= alarm_reg;
        end
    end

endmodule // occp_top

// ==== tb_top.sv ====
// self-checking bench for occp_top
// assumes short lamp test and debounce counts
`timescale 1ns/1ps
`include "occp_consts.vh"
module tb_top;
    reg clk_i, rst_i, cyc, stb, we;
    reg [7:0] adr;
    reg [31:0] dat, q;
    wire [31:0] dat_o;
    wire ack, irq, run_l, pf_l, er_l, hp_l, msg_l, alarm, prun, pfault, perr, phalt, ldone;
    wire sclr, boot, runq, extq, pup, pdn, cclr;
    wire [3:0] bchan;
    wire [7:0] bdev;
    reg [6:0] sw, col;
    reg [4:0] row;
    reg [2:0] fault;
    integer errors, samples_checked, cycles, i, k;
    integer cnt [0:6];
    wire [6:0] pls = {cclr, pdn, pup, extq, runq, boot, sclr};
    always #12.5 clk_i = ~clk_i;
    occp_top #(.LAMP_TEST_CYC(50), .DEBOUNCE_CYC(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq), .proc_run_i(prun),
        .power_fault_i(pfault), .proc_error_i(perr), .proc_halt_point_i(phalt),
        .load_done_i(ldone), .cursor_col_i(col), .cursor_row_i(row),
        .sys_clear_switch_i(sw[0]), .boot_load_switch_i(sw[1]), .run_switch_i(sw[2]),
        .external_irq_switch_i(sw[3]), .power_switch_i(sw[4]),
        .console_clear_switch_i(sw[5]), .alarm_clear_switch_i(sw[6]),
        .chan_sel_i(4'hA), .dev_sel_i(8'h5C), .run_lamp_o(run_l),
        .console_power_fault_lamp_o(pf_l), .processor_fault_lamp_o(er_l),
        .halt_point_lamp_o(hp_l), .message_lamp_o(msg_l), .alarm_o(alarm),
        .system_clear_o(sclr), .boot_load_o(boot), .boot_chan_o(bchan), .boot_dev_o(bdev),
        .run_req_o(runq), .external_irq_o(extq), .power_up_o(pup), .power_down_o(pdn),
        .console_clear_o(cclr));
    occp_proc_model u_proc (.clk_i(clk_i), .rst_i(rst_i), .fault_i(fault),
        .system_clear_i(sclr), .boot_load_i(boot), .run_req_i(runq), .proc_run_o(prun),
        .load_done_o(ldone), .power_fault_o(pfault), .proc_error_o(perr),
        .proc_halt_point_o(phalt));
    ////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        for (k = 0; k < 7; k = k + 1)
            if (pls[k] === 1'b1)
                cnt[k] <= cnt[k] + 1;
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors = errors + 1;
            print_verdict;
        end
    end
    task print_verdict;
    begin
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            errors = errors + 1;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
    begin
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        q = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    end
    endtask
    task press(input integer n);
    begin
        sw[n] <= 1'b1;
        repeat (20) @(posedge clk_i);
        if (n != 4)
            sw[n] <= 1'b0;
        repeat (20) @(posedge clk_i);
    end
    endtask
    task wt(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 0; rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; q = 0;
        sw = 0; col = 0; row = 0; fault = 0; errors = 0; samples_checked = 0; cycles = 0;
        for (i = 0; i < 7; i = i + 1)
            cnt[i] = 0;
        wt(20);
        rst_i <= 1'b0;
        wt(1);
        chk("run_lamp", 0, run_l);
        wb(0, `OCCP_ADDR_ALARM_DUR, 0); chk("alarm_dur", `OCCP_ALARM_DUR_RST, q);
        wb(0, 8'h40, 0); chk("unmapped", 0, q);
        fault <= 3'h7; wt(3);
        wb(0, `OCCP_ADDR_LAMPS, 0); chk("fault_lamps", 32'hE, q & 32'hE);
        chk("pf_pin", 1, pf_l);
        chk("er_pin", 1, er_l);
        chk("hp_pin", 1, hp_l);
        fault <= 3'h0;
        wb(1, `OCCP_ADDR_ALARM_DUR, 6); col <= 7'd71; wt(3);
        chk("alarm_idle", 0, alarm);
        col <= 7'd72; wt(4); chk("alarm_tail", 1, alarm);
        row <= 5'd1; wt(6); chk("alarm_retrig", 1, alarm);
        wt(10); chk("alarm_end", 0, alarm);
        col <= 7'd0; row <= 5'd0; wt(10);
        row <= 5'd23; wt(4); chk("alarm_bottom", 1, alarm);
        wb(0, `OCCP_ADDR_CURSOR, 0); chk("cursor", 32'h1700, q);
        wt(12);
        wb(1, `OCCP_ADDR_CTRL, 2); wt(3);
        chk("msg_lamp", 1, msg_l); chk("alarm_msg", 1, alarm);
        wb(1, `OCCP_ADDR_CTRL, 1); wt(3); chk("alarm_silent", 0, alarm);
        wb(0, `OCCP_ADDR_CTRL, 0); chk("ctrl", 32'h3, q);
        wb(1, `OCCP_ADDR_CTRL, 0); wb(1, `OCCP_ADDR_MASK, 32'h04);
        wb(0, `OCCP_ADDR_MASK, 0); chk("mask", 32'h04, q);
        for (i = 0; i < 7; i = i + 1)
        begin
            press(i);
            if (i == 1)
            begin
                chk("boot_chan", 4'hA, bchan); chk("boot_dev", 8'h5C, bdev);
                chk("load_run_lamp", 1, run_l); chk("irq_masked", 0, irq);
            end
            if (i == 5)
            begin
                wb(0, `OCCP_ADDR_LAMPS, 0);
                chk("lamp_test", 32'h3F, q & 32'h3F);
            end
        end
        sw[4] <= 1'b0; wt(20);
        sw[2] <= 1'b1; wt(2); sw[2] <= 1'b0; wt(20);
        for (i = 0; i < 7; i = i + 1)
            chk("pulse_count", 1, cnt[i]);
        wb(0, `OCCP_ADDR_STATUS, 0); chk("status", 32'hFF, q & 32'hFF);
        chk("msg_cleared", 0, msg_l); chk("alarm_cleared", 0, alarm);
        chk("irq_on", 1, irq); chk("run_lamp_run", 1, run_l);
        wb(0, `OCCP_ADDR_LAMPS, 0); chk("lamps_after", 0, q & 32'h2E);
        chk("fault_pins_off", 3'h0, {hp_l, er_l, pf_l});
        wb(1, `OCCP_ADDR_STATUS, 32'hFF); wt(2);
        wb(0, `OCCP_ADDR_STATUS, 0); chk("status_clr", 0, q & 32'hFF);
        chk("irq_off", 0, irq);
        print_verdict;
    end
endmodule // tb_top
